// *** pkg/lmi_consts.svh ***
`ifndef LMI_CONSTS_SVH
`define LMI_CONSTS_SVH

// target address: fixed upper bits and strap-selected lower bits
`define LMI_ADDR_HI      3'h5
`define LMI_STRAP_GND    2'h0
`define LMI_STRAP_VCC    2'h1
`define LMI_STRAP_SCL    2'h2
`define LMI_STRAP_SDA    2'h3
`define LMI_ALO_GND      4'h0
`define LMI_ALO_VCC      4'hF
`define LMI_ALO_SCL      4'h5
`define LMI_ALO_SDA      4'hA

// device register offsets
`define LMI_REG_MASK     8'hF0
`define LMI_REG_STATUS   8'hF1
`define LMI_REG_PAGE     8'hFD
`define LMI_REG_UNLOCK   8'hFE
`define LMI_UNLOCK_KEY   8'hC5
`define LMI_PAGE_MAX     8'h03
`define LMI_PAGE_LED     2'h0
`define LMI_LED_RD_LO    8'h18
`define LMI_LED_RD_HI    8'h47

// mask register bit positions
`define LMI_MB_AUTO      3
`define LMI_MB_BREATH    2
`define LMI_MB_SHORT     1
`define LMI_MB_OPEN      0

// timing
`define LMI_CLK_NS       10
`define LMI_LINK_NS      160
`define LMI_QTR_CYC      (`LMI_LINK_NS / (4 * `LMI_CLK_NS))
`define LMI_AUTO_CLR_MS  8
`define LMI_AUTO_CLR_CYC (`LMI_AUTO_CLR_MS * 1000000 / `LMI_CLK_NS)

// controller register map and fields
`define LMI_APB_CMD      12'h000
`define LMI_APB_STAT     12'h004
`define LMI_CMD_READ     7
`define LMI_CMD_WDATA    23:16
`define LMI_CMD_RADDR    15:8
`define LMI_CMD_TADDR    6:0

`endif

// *** pkg/lmi_pkg.sv ***
package lmi_pkg;

  // page number held in the page selector
  typedef logic [1:0] lmi_page_t;

  // target receiver and transmitter states
  typedef enum logic [6:0] {
    DS_IDLE = 7'h01,
    DS_ADDR = 7'h02,
    DS_REG  = 7'h04,
    DS_WDAT = 7'h08,
    DS_ACK  = 7'h10,
    DS_RDAT = 7'h20,
    DS_RACK = 7'h40
  } lmi_dst_t;

  // target state
  typedef struct packed {
    logic [2:0]  scl_s;
    logic [2:0]  sda_s;
    logic [1:0]  strap_s0;
    logic [1:0]  strap_s1;
    lmi_dst_t    st;
    lmi_dst_t    after;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic [7:0]  ptr;
    logic        sda_oe;
    logic [3:0]  mask;
    lmi_page_t   page;
    logic [7:0]  unlock;
    logic [4:0]  status;
    logic        irq_n;
    logic [19:0] low_cnt;
    logic        wr_stb;
    lmi_page_t   wr_page;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_data;
  } lmi_dev_t;

  // controller states
  typedef enum logic [3:0] {
    HS_IDLE  = 4'h1,
    HS_START = 4'h2,
    HS_BIT   = 4'h4,
    HS_STOP  = 4'h8
  } lmi_hst_t;

  // controller state
  typedef struct packed {
    lmi_hst_t    st;
    logic [1:0]  ph;
    logic [2:0]  tick_cnt;
    logic [3:0]  bc;
    logic [1:0]  bi;
    logic [7:0]  tx;
    logic [7:0]  rx;
    logic        scl;
    logic        sda_oe;
    logic [1:0]  sda_s;
    logic        busy;
    logic        nack;
    logic        rd;
    logic [6:0]  taddr;
    logic [7:0]  raddr;
    logic [7:0]  wdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } lmi_host_t;

endpackage : lmi_pkg

// *** pkg/lmi_if.sv ***
`timescale 1ns/100ps
interface lmi_if;
  logic scl;          // clock, controller to target
  logic host_sda_o;   // controller data level
  logic host_sda_oe;  // controller drives data line
  logic dev_sda_o;    // target data level
  logic dev_sda_oe;   // target drives data line
  logic sda;          // resolved data line, pulled up when nobody drives

  // open-drain wire with pull-up
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

  modport host   (output scl, host_sda_o, host_sda_oe, input sda);
  modport target (input scl, sda, output dev_sda_o, dev_sda_oe);
endinterface : lmi_if

// *** hw/lmi_target.sv ***
// Operation
// R01 - 7-bit address plus direction, zero writes
// R02 - address 101 plus strap-selected low nibble
// R03 - start and stop from data edges
// R04 - sample data while clock stably high
// R05 - controller sends address byte MSB first
// R06 - target acknowledges matching address
// R07 - controller stops on missing acknowledge
// R08 - register address byte MSB first, acknowledged
// R09 - write data bytes acknowledged each
// R10 - pointer increments during each data acknowledge
// R11 - only FEh, F1h, 18h-47h read back
// R12 - read via repeated start after pointer write
// R13 - select page zero before LED reads
// R14 - page selector maps values 0..3
// R15 - page selector resets to page zero
// R16 - low addresses go to current page
// R17 - page selector write-protected unless unlocked
// R18 - key C5 allows one change, then clears
// R19 - unlock register readable, resets to zero
// R20 - auto release after 8 ms low
// R21 - breath completion gated by mask D2
// R22 - short/open gated by D1/D0, mask resets zero
// R23 - status bits D4..D0 default zero
// R24 - interrupt low while enabled event pending
`timescale 1ns/100ps
`include "lmi_consts.svh"
module lmi_target #(
  parameter int AUTO_CLR_CYC = `LMI_AUTO_CLR_CYC
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // serial link
  lmi_if.target             link,
  // address strap code, from a pin
  input  wire logic [1:0]   bus_id_strap,
  // event pulses from the matrix logic
  input  wire logic [2:0]   breath_done,
  input  wire logic         short_evt,
  input  wire logic         open_evt,
  // open/short register read port
  output logic [7:0]        led_rd_addr,
  input  wire logic [7:0]   led_rd_data,
  // page register write port
  output logic              page_wr_stb,
  output lmi_pkg::lmi_page_t page_wr_page,
  output logic [7:0]        page_wr_addr,
  output logic [7:0]        page_wr_data,
  // status
  output lmi_pkg::lmi_page_t page_sel,
  output logic              irq_out_n
);
  import lmi_pkg::*;

  localparam logic [19:0] AUTO_LAST = 20'(AUTO_CLR_CYC - 1);

  lmi_dev_t   q;          // registered state
  lmi_dev_t   d;          // next state
  logic       scl_rise;   // clock rising edge seen
  logic       scl_fall;   // clock falling edge seen
  logic       start_c;    // start or repeated start
  logic       stop_c;     // stop
  logic [3:0] addr_lo;    // strap-selected low address bits
  logic [7:0] rd_val;     // byte returned for the pointer
  logic [4:0] irq_en;     // per-status-bit enables
  logic [4:0] st_clr;     // status bits to clear

  // edges from the second and third sync stages only
  assign scl_rise = q.scl_s[1] & ~q.scl_s[2];
  assign scl_fall = ~q.scl_s[1] & q.scl_s[2];
  assign start_c  = q.scl_s[1] & q.scl_s[2] & ~q.sda_s[1] & q.sda_s[2]; // R03
  assign stop_c   = q.scl_s[1] & q.scl_s[2] & q.sda_s[1] & ~q.sda_s[2]; // R03

  // low address nibble from the synchronised strap
  always_comb begin
    unique case (q.strap_s1)
      `LMI_STRAP_GND: addr_lo = `LMI_ALO_GND; // R02
      `LMI_STRAP_VCC: addr_lo = `LMI_ALO_VCC; // R02
      `LMI_STRAP_SCL: addr_lo = `LMI_ALO_SCL; // R02
      `LMI_STRAP_SDA: addr_lo = `LMI_ALO_SDA; // R02
    endcase
  end

  // read-back mux; anything else reads zero
  always_comb begin
    rd_val = 8'h00;
    if (q.ptr == `LMI_REG_UNLOCK) begin
      rd_val = q.unlock; // R19
    end else if (q.ptr == `LMI_REG_STATUS) begin
      rd_val = {3'h0, q.status}; // R23
    end else if (q.ptr >= `LMI_LED_RD_LO && q.ptr <= `LMI_LED_RD_HI && q.page == `LMI_PAGE_LED) begin
      rd_val = led_rd_data; // R11 R13
    end
  end

  // breath bits share one enable, short and open have their own
  assign irq_en = {{3{q.mask[`LMI_MB_BREATH]}}, q.mask[`LMI_MB_SHORT], q.mask[`LMI_MB_OPEN]}; // R21 R22

  // next-state logic
  always_comb begin
    d        = q;
    st_clr   = 5'h00;
    d.wr_stb = 1'b0;
    // two-stage synchronisers plus one history stage
    d.scl_s    = {q.scl_s[1:0], link.scl};
    d.sda_s    = {q.sda_s[1:0], link.sda};
    d.strap_s0 = bus_id_strap;
    d.strap_s1 = q.strap_s0;

    if (start_c) begin
      // start or repeated start: expect an address byte
      d.st     = DS_ADDR;
      d.cnt    = 4'h0;
      d.sda_oe = 1'b0;
    end else if (stop_c) begin
      // stop ends any transfer
      d.st     = DS_IDLE; // R03
      d.sda_oe = 1'b0;
    end else if (scl_rise) begin
      if (q.st inside {DS_ADDR, DS_REG, DS_WDAT}) begin
        // shift in MSB first while clock is high
        d.sh  = {q.sh[6:0], q.sda_s[1]}; // R04 R05
        d.cnt = q.cnt + 4'h1;
      end else if (q.st == DS_RACK && q.sda_s[1]) begin
        // controller declined more data
        d.st = DS_IDLE;
      end
    end else if (scl_fall) begin
      unique case (q.st)
        DS_IDLE: begin
          // wait for a start
          d.sda_oe = 1'b0;
        end
        DS_ADDR: begin
          if (q.cnt == 4'h8) begin
            d.cnt = 4'h0;
            if (q.sh[7:1] == {`LMI_ADDR_HI, addr_lo}) begin // R01 R02
              d.sda_oe = 1'b1; // R06
              d.st     = DS_ACK;
              d.after  = q.sh[0] ? DS_RDAT : DS_REG; // R01 R12
            end else begin
              // not ours: stay off the line
              d.st = DS_IDLE;
            end
          end
        end
        DS_REG: begin
          if (q.cnt == 4'h8) begin
            // register address loads the pointer
            d.ptr    = q.sh; // R08
            d.sda_oe = 1'b1; // R08
            d.cnt    = 4'h0;
            d.st     = DS_ACK;
            d.after  = DS_WDAT;
          end
        end
        DS_WDAT: begin
          if (q.cnt == 4'h8) begin
            d.sda_oe = 1'b1; // R09
            d.cnt    = 4'h0;
            d.st     = DS_ACK;
            d.after  = DS_WDAT;
            d.ptr    = q.ptr + 8'h01; // R10
            if (q.ptr == `LMI_REG_MASK) begin
              d.mask = q.sh[3:0];
            end else if (q.ptr == `LMI_REG_PAGE) begin
              // locked unless key present; reserved values ignored
              if (q.unlock == `LMI_UNLOCK_KEY && q.sh <= `LMI_PAGE_MAX) begin // R17
                d.page   = q.sh[1:0]; // R14
                d.unlock = 8'h00; // R18
              end
            end else if (q.ptr == `LMI_REG_UNLOCK) begin
              d.unlock = q.sh; // R18 R19
            end else if (q.ptr < `LMI_REG_MASK) begin
              // page register write forwarded with current page
              d.wr_stb  = 1'b1;
              d.wr_page = q.page; // R16
              d.wr_addr = q.ptr;
              d.wr_data = q.sh;
            end
          end
        end
        DS_ACK, DS_RACK: begin
          if (q.st == DS_RACK || q.after == DS_RDAT) begin
            // load the next read byte and drive its MSB
            d.sh     = rd_val; // R12
            d.sda_oe = ~rd_val[7];
            d.cnt    = 4'h1;
            d.st     = DS_RDAT;
            d.ptr    = q.ptr + 8'h01;
            if (q.ptr == `LMI_REG_STATUS) begin
              st_clr = 5'h1F;
            end
          end else begin
            // release acknowledge, receive next byte
            d.sda_oe = 1'b0;
            d.cnt    = 4'h0;
            d.st     = q.after;
          end
        end
        DS_RDAT: begin
          if (q.cnt == 4'h8) begin
            // release for the controller's acknowledge
            d.sda_oe = 1'b0;
            d.st     = DS_RACK;
          end else begin
            d.sh     = {q.sh[6:0], 1'b0};
            d.sda_oe = ~q.sh[6];
            d.cnt    = q.cnt + 4'h1;
          end
        end
      endcase
    end

    // auto release timer while interrupt is held low
    if (!q.irq_n && q.mask[`LMI_MB_AUTO]) begin
      if (q.low_cnt == AUTO_LAST) begin
        d.low_cnt = 20'h00000;
        st_clr    = 5'h1F; // R20
      end else begin
        d.low_cnt = q.low_cnt + 20'h00001; // R20
      end
    end else begin
      d.low_cnt = 20'h00000;
    end

    // sticky status, a new event wins over a clear
    d.status = (q.status & ~st_clr) | {breath_done[2], breath_done[1], breath_done[0], short_evt, open_evt}; // R23
    d.irq_n  = ~|(d.status & irq_en); // R24
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q         <= '0;
      q.scl_s   <= 3'h7;
      q.sda_s   <= 3'h7;
      q.st      <= DS_IDLE;
      q.after   <= DS_IDLE;
      q.irq_n   <= 1'b1;
      q.page    <= 2'h0; // R15
      q.mask    <= 4'h0; // R22
      q.unlock  <= 8'h00; // R17 R19
    end else begin
      q <= d;
    end
  end

  // outputs straight from state
  assign link.dev_sda_oe = q.sda_oe;
  assign link.dev_sda_o  = 1'b0;
  assign led_rd_addr     = q.ptr;
  assign page_wr_stb     = q.wr_stb;
  assign page_wr_page    = q.wr_page;
  assign page_wr_addr    = q.wr_addr;
  assign page_wr_data    = q.wr_data;
  assign page_sel        = q.page;
  assign irq_out_n       = q.irq_n;

endmodule : lmi_target

// *** hw/lmi_host.sv ***
`timescale 1ns/100ps
`include "lmi_consts.svh"
module lmi_host (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // serial link
  lmi_if.host              link
);
  import lmi_pkg::*;

  localparam logic [2:0] QTR_LAST = 3'(`LMI_QTR_CYC - 1);

  lmi_host_t q;       // registered state
  lmi_host_t d;       // next state
  logic      tick;    // quarter bit-period enable
  logic      recv;    // current byte is read data

  assign tick = q.busy && q.tick_cnt == QTR_LAST;
  assign recv = q.rd && q.bi == 2'h3;

  // byte to send for a given byte index
  function automatic logic [7:0] tx_byte(input logic [1:0] bi, input lmi_host_t s);
    logic [7:0] b;
    unique case (bi)
      2'h0:    b = {s.taddr, 1'b0};
      2'h1:    b = s.raddr;
      2'h2:    b = s.rd ? {s.taddr, 1'b1} : s.wdata;
      default: b = 8'h00;
    endcase
    return b;
  endfunction : tx_byte

  // next-state logic
  always_comb begin
    d          = q;
    d.sda_s    = {q.sda_s[0], link.sda};
    d.tick_cnt = (q.busy && !tick) ? q.tick_cnt + 3'h1 : 3'h0;
    // apb: decode in setup, answer in access with no wait
    if (psel && !penable) begin
      d.pslverr = 1'b0;
      if (paddr == `LMI_APB_CMD) begin
        d.prdata = {8'h00, q.wdata, q.raddr, q.rd, q.taddr};
      end else if (paddr == `LMI_APB_STAT) begin
        d.prdata = {16'h0000, q.rx, 6'h00, q.nack, q.busy};
      end else begin
        d.prdata  = 32'h00000000;
        d.pslverr = 1'b1;
      end
    end
    // a command is taken only while idle
    if (psel && penable && pwrite && paddr == `LMI_APB_CMD && !q.busy) begin
      d.taddr = pwdata[`LMI_CMD_TADDR];
      d.raddr = pwdata[`LMI_CMD_RADDR];
      d.wdata = pwdata[`LMI_CMD_WDATA];
      d.rd    = pwdata[`LMI_CMD_READ];
      d.busy  = 1'b1;
      d.nack  = 1'b0;
      d.st    = HS_START;
      d.ph    = 2'h0;
      d.bi    = 2'h0;
    end
    if (tick) begin
      d.ph = q.ph + 2'h1;
      unique case (q.st)
        HS_IDLE: begin
          d.busy = 1'b0;
        end
        HS_START: begin
          // release, clock high, data falls, clock low
          unique case (q.ph)
            2'h0: d.sda_oe = 1'b0;
            2'h1: d.scl    = 1'b1;
            2'h2: d.sda_oe = 1'b1; // R03
            2'h3: begin
              d.scl = 1'b0;
              d.st  = HS_BIT;
              d.bc  = 4'h0;
              d.tx  = tx_byte(q.bi, q);
            end
          endcase
        end
        HS_BIT: begin
          unique case (q.ph)
            2'h0: d.sda_oe = (q.bc < 4'h8 && !recv) ? ~q.tx[7] : 1'b0; // R04 R05 R06 R09
            2'h1: d.scl = 1'b1;
            2'h2: begin
              if (q.bc < 4'h8) begin
                d.rx = {q.rx[6:0], q.sda_s[1]};
              end else if (!recv) begin
                d.nack = q.sda_s[1]; // R06
              end
            end
            2'h3: begin
              d.scl = 1'b0;
              if (q.bc < 4'h8) begin
                d.bc = q.bc + 4'h1;
                d.tx = {q.tx[6:0], 1'b0};
              end else if (q.nack || (!q.rd && q.bi == 2'h2) || recv) begin
                d.st = HS_STOP; // R07
              end else if (q.rd && q.bi == 2'h1) begin
                d.bi = 2'h2;
                d.st = HS_START; // R12
              end else begin
                d.bi = q.bi + 2'h1; // R08 R09
                d.bc = 4'h0;
                d.tx = tx_byte(q.bi + 2'h1, q);
              end
            end
          endcase
        end
        HS_STOP: begin
          // data low, clock high, data rises
          unique case (q.ph)
            2'h0: d.sda_oe = 1'b1;
            2'h1: d.scl    = 1'b1;
            2'h2: d.sda_oe = 1'b0; // R03
            2'h3: begin
              d.st   = HS_IDLE;
              d.busy = 1'b0;
            end
          endcase
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q        <= '0;
      q.st     <= HS_IDLE;
      q.scl    <= 1'b1;
      q.sda_s  <= 2'h3;
      q.pready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs straight from state
  assign prdata           = q.prdata;
  assign pready           = q.pready;
  assign pslverr          = q.pslverr;
  assign link.scl         = q.scl;
  assign link.host_sda_oe = q.sda_oe;
  assign link.host_sda_o  = 1'b0;

endmodule : lmi_host

// *** testbench/lmi_link_sva.sv ***
`timescale 1ns/100ps
module lmi_link_sva (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link wires
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  logic       scl_p;   // clock one cycle ago
  logic       sda_p;   // data one cycle ago
  logic [3:0] bit_q;   // bit slot within the byte, 8 is the ack slot
  logic       first_q; // still in the address byte
  logic       rd_q;    // direction bit of the last address
  wire        start_w = scl && scl_p && sda_p && !sda;
  wire        stop_w  = scl && scl_p && !sda_p && sda;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // track byte framing from start and clock rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_p   <= 1'b1;
      sda_p   <= 1'b1;
      bit_q   <= 4'h0;
      first_q <= 1'b1;
      rd_q    <= 1'b0;
    end else begin
      scl_p <= scl;
      sda_p <= sda;
      if (start_w) begin
        bit_q   <= 4'h0;
        first_q <= 1'b1;
        rd_q    <= 1'b0;
      end else if (scl && !scl_p) begin
        bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
        if (bit_q == 4'h8) first_q <= 1'b0;
        if (first_q && bit_q == 4'h7) rd_q <= sda;
      end
    end
  end

  AST_HOST_OPEN_DRAIN: assert property (host_sda_o == 1'b0)
    else $error("controller drives data high");
  AST_DEV_OPEN_DRAIN: assert property (dev_sda_o == 1'b0)
    else $error("target drives data high");
  AST_SCL_HIGH_MIN: assert property ($rose(scl) |-> scl[*4])
    else $error("clock high phase too short");
  AST_SCL_LOW_MIN: assert property ($fell(scl) |=> !scl[*3])
    else $error("clock low phase too short");
  AST_SDA_STABLE_HIGH: assert property (scl && $past(scl) && $changed(sda)
    |-> $changed(host_sda_oe) && !dev_sda_oe)
    else $error("data changed while clock high");
  AST_DEV_ACK_SLOT: assert property ($rose(scl) && dev_sda_oe
    |-> (bit_q == 4'h8 && (first_q || !rd_q)) || (rd_q && !first_q && bit_q != 4'h8))
    else $error("target drove outside its slot");
  AST_DEV_HOLD_HIGH: assert property ($rose(scl) && dev_sda_oe |-> dev_sda_oe[*4])
    else $error("target released during clock high");
  AST_STOP_IDLE: assert property (stop_w |-> !dev_sda_oe ##1 (scl && sda)[*4])
    else $error("bus not idle after stop");

  // main scenarios seen
  COV_START: cover property (start_w);
  COV_ADDR_ACK: cover property ($rose(scl) && dev_sda_oe && first_q && bit_q == 4'h8);
  COV_READ_BIT: cover property ($rose(scl) && rd_q && !first_q && bit_q == 4'h0);
  COV_STOP: cover property (stop_w);
endmodule : lmi_link_sva

// *** testbench/tb_led_matrix_i2c_register_access.sv ***
`timescale 1ns/100ps
`include "lmi_consts.svh"
module tb_led_matrix_i2c_register_access;
  import lmi_pkg::*;
  localparam int CLR = 50;                      // shortened auto release count
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  strap;                           // address strap code
  logic [2:0]  breath;                          // breath loop done pulses
  logic        short_evt, open_evt, irq_n, wr_stb;
  logic [7:0]  rd_addr, rd_data, wr_addr, wr_data, seen_addr, seen_data;
  lmi_page_t   wr_page, page, seen_page;
  logic [6:0]  dev;                             // current target address
  int          error_cnt, n_checks, seen_n;

  lmi_if link ();
  lmi_host lmi_host_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.host));
  lmi_target #(.AUTO_CLR_CYC(CLR)) lmi_target_i (.pclk(pclk), .presetn(presetn), .link(link.target),
    .bus_id_strap(strap), .breath_done(breath), .short_evt(short_evt), .open_evt(open_evt),
    .led_rd_addr(rd_addr), .led_rd_data(rd_data), .page_wr_stb(wr_stb), .page_wr_page(wr_page),
    .page_wr_addr(wr_addr), .page_wr_data(wr_data), .page_sel(page), .irq_out_n(irq_n));
  lmi_link_sva lmi_link_sva_i (.pclk(pclk), .presetn(presetn), .scl(link.scl), .host_sda_o(link.host_sda_o),
    .host_sda_oe(link.host_sda_oe), .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe), .sda(link.sda));

  // open/short contents: a pattern of the pointer
  assign rd_data = rd_addr ^ 8'hA5;

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // record every page write strobe
  always @(posedge pclk) begin
    if (wr_stb === 1'b1) begin
      seen_n    <= seen_n + 1;
      seen_page <= wr_page;
      seen_addr <= wr_addr;
      seen_data <= wr_data;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // one apb transfer, held until pready
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one link transfer ordered and polled to the end
  task automatic xfer(input logic [6:0] ta, input logic rd, input logic [7:0] ra, input logic [7:0] wd,
                      output logic [7:0] rb, output logic nk);
    logic [31:0] c, s;
    logic        e;
    c = '0;
    c[`LMI_CMD_TADDR] = ta;
    c[`LMI_CMD_RADDR] = ra;
    c[`LMI_CMD_WDATA] = wd;
    c[`LMI_CMD_READ]  = rd;
    apb(`LMI_APB_CMD, 1'b1, c, s, e);
    s = 32'h1;
    for (int i = 0; i < 500 && s[0] !== 1'b0; i++) apb(`LMI_APB_STAT, 1'b0, 32'h0, s, e);
    chk(s[0], 1'b0, "transfer finished");
    rb = s[15:8];
    nk = s[1];
  endtask : xfer

  task automatic wr(input logic [7:0] ra, input logic [7:0] wd);
    logic [7:0] b;
    logic       nk;
    xfer(dev, 1'b0, ra, wd, b, nk);
  endtask : wr

  task automatic rdchk(input logic [7:0] ra, input logic [7:0] exp);
    logic [7:0] b;
    logic       nk;
    xfer(dev, 1'b1, ra, 8'h00, b, nk);
    chk(b, exp, "read byte");
  endtask : rdchk

  // one-cycle event pulses {breath, short, open}
  task automatic pulse(input logic [4:0] v);
    @(posedge pclk);
    {breath, short_evt, open_evt} <= v;
    @(posedge pclk);
    {breath, short_evt, open_evt} <= 5'h00;
    repeat (3) @(posedge pclk);
  endtask : pulse

  task automatic do_reset(input logic [1:0] code);
    @(posedge pclk);
    presetn <= 1'b0;
    strap   <= code;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask : do_reset

  task automatic t_strap;
    logic [3:0] lo [4] = '{4'h0, 4'hF, 4'h5, 4'hA};
    logic [7:0] b;
    logic       nk;
    for (int i = 0; i < 4; i++) begin
      do_reset(2'(i));
      xfer({3'h5, lo[i]}, 1'b0, 8'hF0, 8'h00, b, nk);
      chk(nk, 1'b0, "own address acked");
      xfer({3'h5, lo[(i + 1) % 4]}, 1'b0, 8'hF0, 8'h00, b, nk);
      chk(nk, 1'b1, "other low bits refused");
      xfer({3'h4, lo[i]}, 1'b1, 8'hFE, 8'h00, b, nk);
      chk(nk, 1'b1, "other high bits refused");
    end
    dev = {3'h5, lo[3]};
    chk(page, 2'h0, "page after reset");
    chk(irq_n, 1'b1, "irq after reset");
    rdchk(8'hFE, 8'h00);
    rdchk(8'hF1, 8'h00);
    $display("test strap and reset done");
  endtask : t_strap

  task automatic t_lock;
    logic [1:0] v [3] = '{2'h3, 2'h1, 2'h0};
    wr(8'hFD, 8'h02);
    chk(page, 2'h0, "locked page write");
    wr(8'hFE, 8'hC5);
    rdchk(8'hFE, 8'hC5);
    wr(8'hFD, 8'h04);
    chk(page, 2'h0, "reserved page value");
    wr(8'hFD, 8'h02);
    chk(page, 2'h2, "unlocked page write");
    rdchk(8'hFE, 8'h00);
    wr(8'hFD, 8'h01);
    chk(page, 2'h2, "second page write");
    for (int i = 0; i < 3; i++) begin
      wr(8'hFE, 8'hC5);
      wr(8'hFD, {6'h00, v[i]});
      chk(page, v[i], "page code");
    end
    $display("test lock done");
  endtask : t_lock

  task automatic t_page;
    int n0;
    n0 = seen_n;
    wr(8'h10, 8'h5A);
    chk({seen_page, seen_addr, seen_data}, {2'h0, 8'h10, 8'h5A}, "page 0 write");
    wr(8'hFE, 8'hC5);
    wr(8'hFD, 8'h03);
    wr(8'h00, 8'h3C);
    chk({seen_page, seen_addr, seen_data}, {2'h3, 8'h00, 8'h3C}, "page 3 write");
    chk(seen_n - n0, 2, "strobe count");
    rdchk(8'h18, 8'h00);
    wr(8'hFE, 8'hC5);
    wr(8'hFD, 8'h00);
    rdchk(8'h18, 8'hBD);
    rdchk(8'h47, 8'hE2);
    rdchk(8'h17, 8'h00);
    rdchk(8'h48, 8'h00);
    $display("test page done");
  endtask : t_page

  task automatic t_irq;
    wr(8'hF0, 8'h00);
    pulse(5'h01);
    chk(irq_n, 1'b1, "masked open");
    rdchk(8'hF1, 8'h01);
    wr(8'hF0, 8'h07);
    pulse(5'h08);
    chk(irq_n, 1'b0, "breath 2 irq");
    repeat (CLR + 20) @(posedge pclk);
    chk(irq_n, 1'b0, "no auto release");
    rdchk(8'hF1, 8'h08);
    chk(irq_n, 1'b1, "irq after clear");
    pulse(5'h02);
    chk(irq_n, 1'b0, "short irq");
    rdchk(8'hF1, 8'h02);
    wr(8'hF0, 8'h0B);
    pulse(5'h04);
    chk(irq_n, 1'b1, "breath masked");
    rdchk(8'hF1, 8'h04);
    pulse(5'h10);
    chk(irq_n, 1'b1, "breath 3 masked");
    wr(8'hF0, 8'h0F);
    pulse(5'h01);
    chk(irq_n, 1'b0, "open irq");
    repeat (CLR + 10) @(posedge pclk);
    chk(irq_n, 1'b1, "auto release");
    rdchk(8'hF1, 8'h00);
    $display("test interrupt done");
  endtask : t_irq

  task automatic t_apb;
    logic [31:0] r;
    logic        e;
    apb(12'h008, 1'b0, 32'h0, r, e);
    chk(e, 1'b1, "unmapped read error");
    chk(r, 32'h0, "unmapped read data");
    apb(12'h00C, 1'b1, 32'hFFFFFFFF, r, e);
    chk(e, 1'b1, "unmapped write");
    // a second command while busy is dropped, the first reads back
    apb(`LMI_APB_CMD, 1'b1, 32'h0000FEDA, r, e);
    apb(`LMI_APB_CMD, 1'b1, 32'h00000000, r, e);
    apb(`LMI_APB_CMD, 1'b0, 32'h0, r, e);
    chk(r, 32'h0000FEDA, "command kept while busy");
    chk(e, 1'b0, "mapped access error");
    repeat (800) @(posedge pclk);
    apb(`LMI_APB_STAT, 1'b0, 32'h0, r, e);
    chk(r, 32'h00000000, "unlock read idle status");
    $display("test apb done");
  endtask : t_apb

  // cut a hang short
  initial begin
    repeat (95000) @(posedge pclk);
    error_cnt++;
    $display("unexpected at %0t: watchdog expired", $time);
    complete_run();
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {strap, breath, short_evt, open_evt} = '0;
    {error_cnt, n_checks, seen_n, dev} = '0;
    t_strap();
    t_lock();
    t_page();
    t_irq();
    t_apb();
    complete_run();
  end
endmodule : tb_led_matrix_i2c_register_access
